// file: rtl/wcd_consts.svh
// constants for the wide channel dictionary and register gateway
`ifndef WCD_CONSTS_SVH
`define WCD_CONSTS_SVH

// ***************************************************************
// dictionary indices
// ***************************************************************
`define WCD_IDX_SIX_IN    16'h2C00
`define WCD_IDX_SIX_OUT   16'h2D00
`define WCD_IDX_EIGHT_IN  16'h3000
`define WCD_IDX_EIGHT_OUT 16'h3100
`define WCD_IDX_GATEWAY   16'h4500

// ***************************************************************
// channel groups
// ***************************************************************
`define WCD_MAX_CH        8'h40
`define WCD_SUB_COUNT     8'h00
`define WCD_SIX_W         48
`define WCD_EIGHT_W       64

// ***************************************************************
// answer lengths in bytes
// ***************************************************************
`define WCD_LEN_COUNT     4'h1
`define WCD_LEN_SIX       4'h6
`define WCD_LEN_EIGHT     4'h8
`define WCD_LEN_GATEWAY   4'h4

// ***************************************************************
// gateway word fields
// ***************************************************************
`define WCD_GW_FLAG       31
`define WCD_GW_TAB_HI     30
`define WCD_GW_TAB_LO     24
`define WCD_GW_REG_HI     23
`define WCD_GW_REG_LO     16
`define WCD_GW_VAL_HI     15
`define WCD_GW_VAL_LO     0

`endif

// file: rtl/wcd_pkg.sv
// types for the wide channel dictionary and register gateway
package wcd_pkg;

   // service-data abort reasons reported with an error answer
   typedef enum logic [2:0] {
      WCD_OK        = 3'h0,
      WCD_NO_OBJECT = 3'h1,
      WCD_NO_SUB    = 3'h2,
      WCD_READ_ONLY = 3'h3,
      WCD_GW_FAIL   = 3'h4,
      WCD_GW_BUSY   = 3'h5
   } wcd_abort_t;

   // gateway sequencer, one-hot
   typedef enum logic [1:0] {
      WCD_GW_IDLE = 2'b01,
      WCD_GW_WAIT = 2'b10
   } wcd_gw_state_t;

endpackage : wcd_pkg

// file: rtl/wcd_dictionary.sv
// object-dictionary bank: wide special channels and register gateway
//
// Operation
// [R1] 6-byte inputs: read-only count at sub 0, 64 read-only 48-bit channels.
// [R2] 6-byte outputs: read-only count, 64 writable 48-bit channels, zeroed.
// [R3] 8-byte inputs: read-only count at sub 0, 64 read-only 64-bit channels.
// [R4] 8-byte outputs: read-only count, 64 writable 64-bit channels, zeroed.
// [R5] one read/write 32-bit gateway entry reaching any station register.
// [R6] gateway top byte: bit 7 access flag, bits 6..0 table number.
// [R7] gateway bytes: flag+table, register number, value high, value low.
// [R8] multi-byte values travel least significant byte first.
// [R9] manager asks a read by writing flag clear; value bytes ignored.
// [R10] after a read request the flag stays one until the value is valid.
// [R11] manager writes a register by setting the flag with all bytes.
// [R12] a failed station access answers with a service-data error.
// [R13] sub-indices above the group's element count are refused with error.
`timescale 1ns/1ns
`include "wcd_consts.svh"
`default_nettype none

module wcd_dictionary
   import wcd_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // service-data request, one cycle
   input  wire logic        req_valid,
   input  wire logic        req_write,
   input  wire logic [15:0] req_index,
   input  wire logic [7:0]  req_subidx,
   input  wire logic [63:0] req_wdata,
   // answer, one cycle later
   output var  logic        rsp_valid,
   output var  logic        rsp_err,
   output var  wcd_abort_t  rsp_code,
   output var  logic [3:0]  rsp_len,
   output var  logic [63:0] rsp_data,
   // fitted channel counts
   input  wire logic [7:0]  cnt_six_in,
   input  wire logic [7:0]  cnt_six_out,
   input  wire logic [7:0]  cnt_eight_in,
   input  wire logic [7:0]  cnt_eight_out,
   // process side: input channel updates
   input  wire logic        pd_in_we,
   input  wire logic        pd_in_eight,
   input  wire logic [5:0]  pd_in_idx,
   input  wire logic [63:0] pd_in_data,
   // process side: output channel readback
   input  wire logic        pd_out_eight,
   input  wire logic [5:0]  pd_out_idx,
   output var  logic [63:0] pd_out_data,
   // station register port
   output var  logic        stn_req,
   output var  logic        stn_write,
   output var  logic [6:0]  stn_table,
   output var  logic [7:0]  stn_regnum,
   output var  logic [15:0] stn_wdata,
   input  wire logic        stn_done,
   input  wire logic        stn_err,
   input  wire logic [15:0] stn_rdata
);

   // ***************************************************************
   // channel storage
   // ***************************************************************
   logic [`WCD_SIX_W-1:0]   six_in_mem    [0:63];
   logic [`WCD_SIX_W-1:0]   six_out_mem   [0:63];
   logic [`WCD_EIGHT_W-1:0] eight_in_mem  [0:63];
   logic [`WCD_EIGHT_W-1:0] eight_out_mem [0:63];

   logic                    six_out_we;
   logic                    eight_out_we;
   logic [5:0]              slot;

   // sub-index n lives in slot n-1
   assign slot = 6'(req_subidx - 8'h01);

   // reset clears every slot so all channels start at zero
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 64; i++) begin
            six_in_mem[i]    <= '0;       // [R1]
            six_out_mem[i]   <= '0;       // [R2]
            eight_in_mem[i]  <= '0;       // [R3]
            eight_out_mem[i] <= '0;       // [R4]
         end
      end else begin
         if (pd_in_we && !pd_in_eight) begin
            six_in_mem[pd_in_idx] <= pd_in_data[`WCD_SIX_W-1:0];
         end
         if (pd_in_we && pd_in_eight) begin
            eight_in_mem[pd_in_idx] <= pd_in_data;
         end
         if (six_out_we) begin
            six_out_mem[slot] <= req_wdata[`WCD_SIX_W-1:0]; // [R2]
         end
         if (eight_out_we) begin
            eight_out_mem[slot] <= req_wdata;               // [R4]
         end
      end
   end

   // ***************************************************************
   // request decode
   // ***************************************************************
   logic        rsp_valid_r, rsp_valid_nxt;
   logic        rsp_err_r, rsp_err_nxt;
   wcd_abort_t  rsp_code_r, rsp_code_nxt;
   logic [3:0]  rsp_len_r, rsp_len_nxt;
   logic [63:0] rsp_data_r, rsp_data_nxt;
   logic [63:0] pd_out_data_r, pd_out_data_nxt;

   wcd_gw_state_t gw_state_r, gw_state_nxt;
   logic [31:0] gw_word_r, gw_word_nxt;
   logic        gw_err_r, gw_err_nxt;
   logic        stn_req_r, stn_req_nxt;
   logic        gw_wr_r, gw_wr_nxt;

   logic [7:0]  grp_cnt;
   logic        grp_hit;
   logic        grp_ro;
   logic        grp_wide;
   logic [63:0] grp_data;

   always_comb begin
      grp_hit  = 1'b1;
      grp_ro   = 1'b1;
      grp_wide = 1'b0;
      grp_cnt  = 8'h00;
      grp_data = '0;
      case (req_index)
         `WCD_IDX_SIX_IN: begin
            grp_cnt  = cnt_six_in;
            grp_data = {16'h0000, six_in_mem[slot]};
         end
         `WCD_IDX_SIX_OUT: begin
            grp_ro   = 1'b0;
            grp_cnt  = cnt_six_out;
            grp_data = {16'h0000, six_out_mem[slot]};
         end
         `WCD_IDX_EIGHT_IN: begin
            grp_wide = 1'b1;
            grp_cnt  = cnt_eight_in;
            grp_data = eight_in_mem[slot];
         end
         `WCD_IDX_EIGHT_OUT: begin
            grp_ro   = 1'b0;
            grp_wide = 1'b1;
            grp_cnt  = cnt_eight_out;
            grp_data = eight_out_mem[slot];
         end
         default: begin
            grp_hit  = 1'b0;
         end
      endcase
   end

   // ***************************************************************
   // answer and gateway next state
   // ***************************************************************
   always_comb begin
      rsp_valid_nxt = req_valid;
      rsp_err_nxt   = 1'b0;
      rsp_code_nxt  = WCD_OK;
      rsp_len_nxt   = 4'h0;
      rsp_data_nxt  = '0;
      six_out_we    = 1'b0;
      eight_out_we  = 1'b0;
      gw_state_nxt  = gw_state_r;
      gw_word_nxt   = gw_word_r;
      gw_err_nxt    = gw_err_r;
      gw_wr_nxt     = gw_wr_r;
      stn_req_nxt   = 1'b0;
      pd_out_data_nxt = pd_out_eight ? eight_out_mem[pd_out_idx]
                      : {16'h0000, six_out_mem[pd_out_idx]};

      // station completes; its error is sticky until the manager reads it or writes a new gateway request
      if (gw_state_r == WCD_GW_WAIT && stn_done) begin
         gw_state_nxt = WCD_GW_IDLE;
         if (stn_err) begin
            gw_err_nxt = 1'b1;                                  // [R12]
         end else if (!gw_wr_r) begin
            gw_word_nxt[`WCD_GW_VAL_HI:`WCD_GW_VAL_LO] = stn_rdata;
         end
         gw_word_nxt[`WCD_GW_FLAG] = 1'b0;                      // [R10]
      end

      if (req_valid && grp_hit) begin
         if (req_subidx > grp_cnt || req_subidx > `WCD_MAX_CH) begin
            rsp_err_nxt  = 1'b1;                                // [R13]
            rsp_code_nxt = WCD_NO_SUB;
         end else if (req_write && (grp_ro ||
                      req_subidx == `WCD_SUB_COUNT)) begin
            rsp_err_nxt  = 1'b1;                                // [R1]
            rsp_code_nxt = WCD_READ_ONLY;
         end else if (req_write) begin
            six_out_we   = !grp_wide;                           // [R2]
            eight_out_we = grp_wide;                            // [R4]
         end else if (req_subidx == `WCD_SUB_COUNT) begin
            rsp_len_nxt  = `WCD_LEN_COUNT;
            rsp_data_nxt = {56'h0, grp_cnt};                    // [R3]
         end else begin
            // byte 0 of the answer is the value's lowest byte
            rsp_len_nxt  = grp_wide ? `WCD_LEN_EIGHT : `WCD_LEN_SIX;
            rsp_data_nxt = grp_data;                            // [R8]
         end
      end else if (req_valid && req_index == `WCD_IDX_GATEWAY) begin
         if (req_subidx != `WCD_SUB_COUNT) begin
            rsp_err_nxt  = 1'b1;
            rsp_code_nxt = WCD_NO_SUB;
         end else if (req_write && gw_state_r == WCD_GW_WAIT) begin
            // one station access at a time; a second is refused
            rsp_err_nxt  = 1'b1;
            rsp_code_nxt = WCD_GW_BUSY;
         end else if (req_write) begin
            gw_state_nxt = WCD_GW_WAIT;                         // [R5]
            stn_req_nxt  = 1'b1;
            gw_err_nxt   = 1'b0;
            gw_wr_nxt    = req_wdata[`WCD_GW_FLAG];             // [R11]
            gw_word_nxt  = req_wdata[31:0];                     // [R7]
            // a read request shows the flag until the value arrives
            gw_word_nxt[`WCD_GW_FLAG] = 1'b1;                   // [R10]
         end else if (gw_err_r && gw_state_r == WCD_GW_IDLE) begin
            rsp_err_nxt  = 1'b1;                                // [R12]
            rsp_code_nxt = WCD_GW_FAIL;
            gw_err_nxt   = 1'b0;
         end else begin
            rsp_len_nxt  = `WCD_LEN_GATEWAY;
            rsp_data_nxt = {32'h0, gw_word_r};                  // [R8]
         end
      end else if (req_valid) begin
         rsp_err_nxt  = 1'b1;
         rsp_code_nxt = WCD_NO_OBJECT;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rsp_valid_r   <= 1'b0;
         rsp_err_r     <= 1'b0;
         rsp_code_r    <= WCD_OK;
         rsp_len_r     <= 4'h0;
         rsp_data_r    <= '0;
         pd_out_data_r <= '0;
         gw_state_r    <= WCD_GW_IDLE;
         gw_word_r     <= '0;
         gw_err_r      <= 1'b0;
         gw_wr_r       <= 1'b0;
         stn_req_r     <= 1'b0;
      end else begin
         rsp_valid_r   <= rsp_valid_nxt;
         rsp_err_r     <= rsp_err_nxt;
         rsp_code_r    <= rsp_code_nxt;
         rsp_len_r     <= rsp_len_nxt;
         rsp_data_r    <= rsp_data_nxt;
         pd_out_data_r <= pd_out_data_nxt;
         gw_state_r    <= gw_state_nxt;
         gw_word_r     <= gw_word_nxt;
         gw_err_r      <= gw_err_nxt;
         gw_wr_r       <= gw_wr_nxt;
         stn_req_r     <= stn_req_nxt;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign rsp_valid   = rsp_valid_r;
   assign rsp_err     = rsp_err_r;
   assign rsp_code    = rsp_code_r;
   assign rsp_len     = rsp_len_r;
   assign rsp_data    = rsp_data_r;
   assign pd_out_data = pd_out_data_r;
   assign stn_req     = stn_req_r;
   // field split of the latched gateway word
   assign stn_write   = gw_wr_r;                                     // [R6]
   assign stn_table   = gw_word_r[`WCD_GW_TAB_HI:`WCD_GW_TAB_LO];    // [R6]
   assign stn_regnum  = gw_word_r[`WCD_GW_REG_HI:`WCD_GW_REG_LO];    // [R7]
   assign stn_wdata   = gw_word_r[`WCD_GW_VAL_HI:`WCD_GW_VAL_LO];    // [R7]

endmodule : wcd_dictionary

`default_nettype wire

// file: dv/wcd_dictionary_chk.sv
// port checker for the wide channel dictionary
`timescale 1ns/1ns
`default_nettype none
module wcd_dictionary_chk
   import wcd_pkg::*;
(
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic        req_valid,
   input wire logic        req_write,
   input wire logic [15:0] req_index,
   input wire logic [7:0]  req_subidx,
   input wire logic [63:0] req_wdata,
   input wire logic        rsp_valid,
   input wire logic        rsp_err,
   input wire wcd_abort_t  rsp_code,
   input wire logic [3:0]  rsp_len,
   input wire logic [63:0] rsp_data,
   input wire logic [7:0]  cnt_six_in,
   input wire logic [7:0]  cnt_six_out,
   input wire logic [7:0]  cnt_eight_out,
   input wire logic        stn_req,
   input wire logic        stn_write,
   input wire logic [6:0]  stn_table,
   input wire logic [7:0]  stn_regnum,
   input wire logic [15:0] stn_wdata
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_answer;
      req_valid |=> rsp_valid;
   endproperty
   a_answer: assert property (p_answer)
      else $error("request unanswered");
   property p_cause;
      rsp_valid |-> $past(req_valid);
   endproperty
   a_cause: assert property (p_cause)
      else $error("answer without request");
   property p_no_obj;
      req_valid && !(req_index inside {16'h2c00, 16'h2d00, 16'h3000,
      16'h3100, 16'h4500}) |=> rsp_err && rsp_code == WCD_NO_OBJECT;
   endproperty
   a_no_obj: assert property (p_no_obj)
      else $error("unknown index taken");
   // only the four channel groups; writing sub 0 answers read-only
   property p_read_only;
      req_valid && req_write && req_subidx == 8'h00 && req_index inside
      {16'h2c00, 16'h2d00, 16'h3000, 16'h3100}
      |=> rsp_err && rsp_code == WCD_READ_ONLY;
   endproperty
   a_read_only: assert property (p_read_only)
      else $error("count written");
   property p_sub_range;
      req_valid && req_index == 16'h2d00 && (req_subidx > cnt_six_out ||
      req_subidx > 8'h40) |=> rsp_err && rsp_code == WCD_NO_SUB;
   endproperty
   a_sub_range: assert property (p_sub_range)
      else $error("bad sub taken");
   property p_len8;
      req_valid && !req_write && req_index == 16'h3100 &&
      req_subidx != 8'h00 && req_subidx <= cnt_eight_out &&
      req_subidx <= 8'h40 |=> !rsp_err && rsp_len == 4'h8;
   endproperty
   a_len8: assert property (p_len8)
      else $error("wide read length wrong");
   property p_count;
      req_valid && !req_write && req_index == 16'h2c00 &&
      req_subidx == 8'h00
      |=> rsp_len == 4'h1 && rsp_data == 64'($past(cnt_six_in));
   endproperty
   a_count: assert property (p_count)
      else $error("count read wrong");
   property p_stn_cause;
      stn_req |-> $past(req_valid) && $past(req_write) &&
      $past(req_index) == 16'h4500;
   endproperty
   a_stn_cause: assert property (p_stn_cause)
      else $error("stray access");
   property p_stn_fields;
      stn_req |-> {stn_write, stn_table, stn_regnum, stn_wdata} ==
      32'($past(req_wdata));
   endproperty
   a_stn_fields: assert property (p_stn_fields)
      else $error("word split");
endmodule : wcd_dictionary_chk
`default_nettype wire

// file: dv/wcd_station_model.sv
// station register model answering the gateway port
`timescale 1ns/1ns
`default_nettype none
module wcd_station_model (
   input  wire logic        clock,
   input  wire logic        stn_req,
   input  wire logic [6:0]  stn_table,
   input  wire logic [7:0]  stn_regnum,
   input  wire logic [3:0]  lat,
   input  wire logic        fail,
   output var  logic        stn_done = 1'b0,
   output var  logic        stn_err = 1'b0,
   output var  logic [15:0] stn_rdata = 16'h0000
);
   int n = 0;
   // answer encodes the address; data toggles when not valid
   always @(posedge clock) begin
      stn_done <= n == 1;
      stn_err <= n == 1 && fail;
      stn_rdata <= n == 1 ? {stn_regnum, 1'b0, stn_table} : ~stn_rdata;
      n <= stn_req ? int'(lat) : (n > 0 ? n - 1 : 0);
   end
endmodule : wcd_station_model
`default_nettype wire

// file: dv/tb_wide_channel_dictionary_regaccess.sv
// self-checking bench for the wide channel dictionary
`timescale 1ns/1ns
`default_nettype none
module tb_wide_channel_dictionary_regaccess;
   import wcd_pkg::*;
   typedef struct {logic w; logic [15:0] i; logic [7:0] s; logic [63:0] d;
      logic [2:0] c; logic [3:0] l;} wcd_row_t;
   logic clock = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
   logic [15:0] req_index = 16'h0000;
   logic [7:0] req_subidx = 8'h00, cnt_six_out = 8'h03, cnt_eight_out = 8'h40;
   logic [7:0] cnt_six_in = 8'h40, cnt_eight_in = 8'h02;
   logic [63:0] req_wdata = 64'h0, pd_in_data = 64'h0;
   logic pd_in_we = 1'b0, pd_in_eight = 1'b1, pd_out_eight = 1'b1, fail = 1'b0;
   logic [5:0] pd_out_idx = 6'h3f, pd_in_idx = 6'h00;
   logic rsp_valid, rsp_err, stn_req, stn_write, stn_done, stn_err;
   wcd_abort_t rsp_code;
   logic [3:0] rsp_len;
   logic [63:0] rsp_data, pd_out_data;
   logic [6:0] stn_table;
   logic [7:0] stn_regnum;
   logic [15:0] stn_wdata, stn_rdata;
   int bad_count = 0, n_tests = 0, k;
   wcd_row_t rows [16] = '{
      '{1'b0, 16'h2d00, 8'h01, 64'h0, 3'h0, 4'h6},
      '{1'b1, 16'h2d00, 8'h01, 64'h1122_3344_5566, 3'h0, 4'h0},
      '{1'b0, 16'h2d00, 8'h01, 64'h1122_3344_5566, 3'h0, 4'h6},
      '{1'b0, 16'h2d00, 8'h00, 64'h3, 3'h0, 4'h1},
      '{1'b0, 16'h2d00, 8'h04, 64'h0, 3'h2, 4'h0},
      '{1'b1, 16'h2d00, 8'h00, 64'h0, 3'h3, 4'h0},
      '{1'b1, 16'h2c00, 8'h01, 64'h0, 3'h3, 4'h0},
      '{1'b0, 16'h2c00, 8'h00, 64'h40, 3'h0, 4'h1},
      '{1'b0, 16'h2c00, 8'h01, 64'h0000_7788_99aa_bbcc, 3'h0, 4'h6},
      '{1'b1, 16'h3100, 8'h40, 64'h0102_0304_0506_0708, 3'h0, 4'h0},
      '{1'b0, 16'h3100, 8'h40, 64'h0102_0304_0506_0708, 3'h0, 4'h8},
      '{1'b0, 16'h3000, 8'h01, 64'ha5a5_0000_1234_5678, 3'h0, 4'h8},
      '{1'b0, 16'h3000, 8'h03, 64'h0, 3'h2, 4'h0},
      '{1'b0, 16'h3000, 8'h41, 64'h0, 3'h2, 4'h0},
      '{1'b0, 16'h1234, 8'h00, 64'h0, 3'h1, 4'h0},
      '{1'b0, 16'h4500, 8'h01, 64'h0, 3'h2, 4'h0}};
   always #25 clock = ~clock;
   wcd_dictionary dut (.*);
   wcd_station_model u_stn (.lat(4'h8), .*);
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic sdo(input logic w, input logic [15:0] i,
      input logic [7:0] s, input logic [63:0] d);
      @(negedge clock);
      {req_valid, req_write, req_index, req_subidx, req_wdata} =
         {1'b1, w, i, s, d};
      @(negedge clock);
      req_valid = 1'b0;
      // the answer stands for one cycle only, so callers look right now
      chk(rsp_valid, 1'b1);
   endtask : sdo
   task automatic wait_done;
      for (k = 0; k < 20 && stn_done !== 1'b1; k++) @(negedge clock);
      chk(stn_done, 1'b1);
      @(negedge clock);
   endtask : wait_done
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   initial begin
      repeat (2000) @(posedge clock);
      bad_count++;
      complete_run();
   end
   initial begin
      repeat (20) @(negedge clock);
      {sys_rst, pd_in_we, pd_in_data} = {2'b01, 64'ha5a5_0000_1234_5678};
      @(negedge clock);
      // second update fills the first 6-byte input slot
      {pd_in_eight, pd_in_data} = {1'b0, 64'h0000_7788_99aa_bbcc};
      @(negedge clock);
      pd_in_we = 1'b0;
      foreach (rows[j]) begin
         sdo(rows[j].w, rows[j].i, rows[j].s, rows[j].d);
         chk({rsp_err, rsp_code, rsp_len},
            {rows[j].c != 3'h0, rows[j].c, rows[j].l});
         if (!rows[j].w && rows[j].c == 3'h0) begin
            chk(rsp_data, rows[j].d);
         end
         $display("test row %0d done", j);
      end
      chk(pd_out_data, 64'h0102_0304_0506_0708);
      {pd_out_eight, pd_out_idx} = {1'b0, 6'h00};
      @(negedge clock);
      chk(pd_out_data, 64'h0000_1122_3344_5566);
      cnt_eight_out = 8'h00;
      sdo(1'b0, 16'h3100, 8'h01, 64'h0);
      chk(rsp_code, WCD_NO_SUB);
      $display("test process side done");
      sdo(1'b1, 16'h4500, 8'h00, 64'h6403_0000);
      sdo(1'b0, 16'h4500, 8'h00, 64'h0);
      chk({rsp_len, rsp_data}, {4'h4, 64'he403_0000});
      sdo(1'b1, 16'h4500, 8'h00, 64'he463_0007);
      chk(rsp_code, WCD_GW_BUSY);
      wait_done();
      sdo(1'b0, 16'h4500, 8'h00, 64'h0);
      chk(rsp_data, 64'h6403_0364);
      sdo(1'b1, 16'h4500, 8'h00, 64'he463_0007);
      chk({stn_req, stn_write, stn_table, stn_regnum, stn_wdata},
         {2'b11, 7'h64, 8'h63, 16'h0007});
      wait_done();
      sdo(1'b0, 16'h4500, 8'h00, 64'h0);
      chk(rsp_data, 64'h6463_0007);
      fail = 1'b1;
      sdo(1'b1, 16'h4500, 8'h00, 64'h0501_0000);
      wait_done();
      fail = 1'b0;
      sdo(1'b0, 16'h4500, 8'h00, 64'h0);
      chk({rsp_err, rsp_code}, {1'b1, WCD_GW_FAIL});
      sdo(1'b0, 16'h4500, 8'h00, 64'h0);
      chk(rsp_err, 1'b0);
      $display("test gateway done");
      sys_rst = 1'b1;
      @(negedge clock);
      chk(pd_out_data, 64'h0);
      @(negedge clock);
      sys_rst = 1'b0;
      sdo(1'b0, 16'h2d00, 8'h01, 64'h0);
      chk(rsp_data, 64'h0);
      $display("test reset done");
      complete_run();
   end
endmodule : tb_wide_channel_dictionary_regaccess
bind wcd_dictionary wcd_dictionary_chk u_chk (.*);
`default_nettype wire
